// ### hw/pause_release_and_reset_ctrl.sv
// Pause-release and reset sequencer with its APB control registers.
// Assumes interrupt, halt and watchdog inputs are synchronous to pclk;
// the reset pin is asynchronous and is synchronised here.
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ns
// Functional notes
// - Unmasked request leaves pause; masked stays.
// - Global enable picks vectored service or resume.
// - Vectored service starts 9-10 CPU clocks later.
// - Plain resume starts 1-2 CPU clocks later.
// - Non-maskable request always leaves pause vectored.
// - Reset pin during pause does ordinary reset.
// - Reset comes from pin or watchdog overflow.
// - Both resets start at vector 0000H/0001H.
// - Reset and regulator wait: pins hi-Z, subclock on.
// - Reset gives low speed; bit 1 selects.
// - Pin low holds reset; then two waits.
// - External reset stops main oscillator, waits run it.
// - Watchdog reset lasts wait time, then 0.5 s.
// - Watchdog reset keeps prior main oscillator state.
// - Subsystem oscillator always runs, reset-immune.
// - Reset loads PROGRAM_STATUS_WORD, clock, port, interrupt values.
// - Reset loads serial unit values.
// - Reset clears timer counters and captures.
// - Only program counter undefined during reset.
// - Pause stops CPU clock, keeps oscillators, state.
module pause_release_and_reset_ctrl
  import pause_reset_pkg::*;
#(
  parameter int INT_RST_WAIT = INT_RST_CYC,   // Internal reset wait, pclk cycles.
  parameter int REG_STAB     = REG_STAB_CYC   // Regulator wait, pclk cycles.
) (
  // Clock and power-on reset.
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave.
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output      logic [31:0]        prdata,
  output      logic               pready,
  output      logic               pslverr,
  // Reset sources.
  input  wire logic               reset_pin_n,
  input  wire logic               wdt_overflow,
  // Interrupt sources and CPU halt request.
  input  wire logic [IRQ_NUM-1:0] irq_req,
  input  wire logic               nmi_req,
  input  wire logic               halt_req,
  // Core, clock and reset-image outputs.
  output      cpu_ctrl_type       cpu_ctrl,
  output      osc_ctrl_type       osc_ctrl,
  output      init_image_type     init_image
);

  // Whole module state in one record.
  typedef struct packed {
    state_type          state;      // Sequencer state.
    logic [1:0]         pin_sync;   // Reset pin synchroniser.
    logic [CNT_W-1:0]   cnt;        // Wait counter.
    logic [1:0]         div;        // CPU clock divider.
    logic               slow_lat;   // Speed in force at pause entry.
    logic               mcc_pre;    // Main clock stop before watchdog reset.
    logic               wdt_cause;  // Last reset came from the watchdog.
    logic               wake_vec;   // Wake ends in vectored service.
    logic               wake_nmi;   // Wake caused by non-maskable request.
    logic [7:0]         program_status_word;        // program_status_word.
    logic [7:0]         processor_clock_control;        // processor_clock_control.
    logic               main_clock_stop_control;        // main_clock_stop_control.
    logic [IRQ_NUM-1:0] req;        // irq_request_flags.
    logic [IRQ_NUM-1:0] mask;       // irq_mask_flags.
    logic [31:0]        rdata;      // APB read data.
    logic               main_osc;   // Main oscillator enable.
    logic               pc_valid;   // Program counter defined.
    logic               fetch;      // Vector fetch pulse.
    logic               service;    // Service start pulse.
    logic               resume;     // Resume pulse.
    init_image_type     image;      // Peripheral reset image.
  } ctrl_state_type;

  localparam ctrl_state_type S_RESET = '{
    state: ST_EXT_RESET, pin_sync: 2'h0, cnt: '0, div: 2'h0, slow_lat: 1'b1,
    mcc_pre: 1'b0, wdt_cause: 1'b0, wake_vec: 1'b0, wake_nmi: 1'b0,
    program_status_word: PSW_RST, processor_clock_control: PCC_RST, main_clock_stop_control: 1'b0, req: REQ_RST, mask: MASK_RST,
    rdata: 32'h0000_0000, main_osc: 1'b0, pc_valid: 1'b0, fetch: 1'b0,
    service: 1'b0, resume: 1'b0, image: INIT_IMAGE};

  ctrl_state_type s;          // Current state.
  ctrl_state_type n;          // Next state.
  logic           tick;       // One CPU clock elapses this pclk.
  logic           unmasked;   // Some request has its mask cleared.
  logic           pin_high;   // Synchronised reset pin level.
  logic           wr_access;  // APB write in its access phase.

  // Reload value of the divider for a speed selection.
  function automatic logic [1:0] div_load(input logic slow);
    return slow ? 2'(DIV_SLOW - 1) : 2'(DIV_FAST - 1);
  endfunction : div_load

  // States in which the core is held in reset.
  function automatic logic in_reset(input state_type st);
    return (st == ST_EXT_RESET) || (st == ST_WDT_RESET) ||
           (st == ST_INT_WAIT) || (st == ST_REG_WAIT);
  endfunction : in_reset

  // Address decode, shared by write and error.
  function automatic logic addr_hit(input logic [7:0] a);
    return (a == ADDR_PSW) || (a == ADDR_PCC) || (a == ADDR_MCC) ||
           (a == ADDR_REQ) || (a == ADDR_MASK) || (a == ADDR_STAT);
  endfunction : addr_hit

  assign pin_high  = s.pin_sync[1];
  assign unmasked  = |(s.req & ~s.mask);
  assign wr_access = psel && penable && pwrite && addr_hit(paddr);
  assign tick      = (s.div == 2'h0);

  // Zero-wait slave; unmapped addresses answer with an error.
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_hit(paddr);
  assign prdata  = s.rdata;

  // All next-state logic of the sequencer and registers.
  always_comb begin
    n          = s;
    n.fetch    = 1'b0;
    n.service  = 1'b0;
    n.resume   = 1'b0;
    n.image    = INIT_IMAGE;
    n.pin_sync = {s.pin_sync[0], reset_pin_n};

    // The divider runs on the speed latched at pause entry while paused,
    // so a speed write cannot stretch an ongoing wake count.
    if (tick) begin
      if ((s.state == ST_PAUSE) || (s.state == ST_WAKE)) begin
        n.div = div_load(s.slow_lat);
      end else begin
        n.div = div_load(s.processor_clock_control[PCC_SPEED_BIT]);
      end
    end else begin
      n.div = s.div - 2'h1;
    end

    // Request flags: write one to clear, a new request wins over the clear.
    if (wr_access && (paddr == ADDR_REQ)) begin
      n.req = (s.req & ~pwdata[IRQ_NUM-1:0]) | irq_req;
    end else begin
      n.req = s.req | irq_req;
    end

    // Register writes.
    if (wr_access) begin
      case (paddr)
        ADDR_PSW:  n.program_status_word  = pwdata[7:0];
        ADDR_PCC:  n.processor_clock_control  = pwdata[7:0];
        ADDR_MCC:  n.main_clock_stop_control  = pwdata[0];
        ADDR_MASK: n.mask = pwdata[IRQ_NUM-1:0];
        default:   n.main_clock_stop_control  = s.main_clock_stop_control;
      endcase
    end

    // Read data is captured in the setup phase, ready for the access edge.
    if (psel && !penable && !pwrite) begin
      case (paddr)
        ADDR_PSW:  n.rdata = {24'h0000_00, s.program_status_word};
        ADDR_PCC:  n.rdata = {24'h0000_00, s.processor_clock_control};
        ADDR_MCC:  n.rdata = {31'h0000_0000, s.main_clock_stop_control};
        ADDR_REQ:  n.rdata = {{(32-IRQ_NUM){1'b0}}, s.req};
        ADDR_MASK: n.rdata = {{(32-IRQ_NUM){1'b0}}, s.mask};
        ADDR_STAT: n.rdata = {26'h000_0000, s.wdt_cause, s.pc_valid, 1'b0,
                              s.state};
        default:   n.rdata = 32'h0000_0000;
      endcase
    end

    // Sequencer.
    case (s.state)
      ST_EXT_RESET: begin
        // Held as long as the pin is low.
        if (pin_high) begin
          n.state = ST_INT_WAIT;
          n.cnt   = CNT_W'(INT_RST_WAIT - 1);
        end
      end
      ST_WDT_RESET, ST_INT_WAIT: begin
        // Watchdog reset lasts the internal reset wait time.
        if (s.cnt == '0) begin
          n.state = ST_REG_WAIT;
          n.cnt   = CNT_W'(REG_STAB - 1);
        end else begin
          n.cnt = s.cnt - 1'b1;
        end
      end
      ST_REG_WAIT: begin
        if (s.cnt == '0) begin
          n.state    = ST_RUN;
          n.fetch    = 1'b1;
          n.pc_valid = 1'b1;
        end else begin
          n.cnt = s.cnt - 1'b1;
        end
      end
      ST_RUN: begin
        // CPU stops its own clock; everything else keeps its value.
        if (halt_req) begin
          n.state    = ST_PAUSE;
          n.slow_lat = s.processor_clock_control[PCC_SPEED_BIT];
        end
      end
      ST_PAUSE: begin
        // Masked requests alone never release the pause.
        if (nmi_req || unmasked) begin
          n.state    = ST_WAKE;
          n.wake_nmi = nmi_req;
          n.wake_vec = nmi_req || s.program_status_word[PSW_IE_BIT];
          n.cnt      = (nmi_req || s.program_status_word[PSW_IE_BIT]) ?
                       CNT_W'(WAKE_VEC_CLKS) : CNT_W'(WAKE_RES_CLKS);
          // Restart the divider so every counted CPU clock is a whole one.
          n.div      = div_load(s.slow_lat);
        end
      end
      ST_WAKE: begin
        // Whole CPU clocks only, since the divider restarted at release.
        if (tick) begin
          if (s.cnt == CNT_W'(1)) begin
            n.state = ST_RUN;
            if (s.wake_vec) begin
              n.service            = 1'b1;
              n.program_status_word[PSW_IE_BIT]    = 1'b0;
            end else begin
              n.resume = 1'b1;
            end
          end else begin
            n.cnt = s.cnt - 1'b1;
          end
        end
      end
      default: n.state = ST_EXT_RESET;
    endcase

    // A watchdog overflow inside a reset state is dropped: the wait already
    // in progress ends in the same reset exit.
    // Reset sources override everything; the pin has priority.
    if (!pin_high) begin
      n.state     = ST_EXT_RESET;
      n.wdt_cause = 1'b0;
    end else if (wdt_overflow && !in_reset(s.state)) begin
      n.state     = ST_WDT_RESET;
      n.cnt       = CNT_W'(INT_RST_WAIT - 1);
      n.mcc_pre   = s.main_clock_stop_control;
      n.wdt_cause = 1'b1;
    end

    // Forcing from n.state rather than s.state makes the values hold from the
    // very first reset cycle, which the reset-value check relies on.
    // Both reset kinds load the same values from the first reset cycle on.
    if (in_reset(n.state)) begin
      n.program_status_word      = PSW_RST;
      n.processor_clock_control      = PCC_RST;
      n.main_clock_stop_control      = 1'b0;
      n.req      = REQ_RST;
      n.mask     = MASK_RST;
      n.pc_valid = 1'b0;
    end

    // Main oscillator: stopped under the pin, prior state under watchdog.
    case (n.state)
      ST_EXT_RESET: n.main_osc = 1'b0;
      ST_WDT_RESET: n.main_osc = !n.mcc_pre;
      ST_INT_WAIT:  n.main_osc = 1'b1;
      ST_REG_WAIT:  n.main_osc = 1'b1;
      default:      n.main_osc = !n.main_clock_stop_control;
    endcase
  end

  // The synchroniser lives in the record too; only its second stage is read.
  // State register; power-on reset loads constants only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= S_RESET;
    end else begin
      s <= n;
    end
  end

  // Pads follow the core reset, so they stay hi-Z through both waits.
  // Outputs toward core, pads and oscillators.
  assign cpu_ctrl.core_reset    = in_reset(s.state);
  assign cpu_ctrl.cpu_clk_en    = (s.state == ST_RUN);
  assign cpu_ctrl.pc_valid      = s.pc_valid;
  assign cpu_ctrl.vector_fetch  = s.fetch;
  assign cpu_ctrl.vector_addr   = VEC_ADDR_LO;
  assign cpu_ctrl.service_start = s.service;
  assign cpu_ctrl.service_nmi   = s.wake_nmi;
  assign cpu_ctrl.resume_start  = s.resume;
  assign osc_ctrl.main_osc_run  = s.main_osc;
  assign osc_ctrl.sub_osc_run   = 1'b1;
  assign osc_ctrl.ports_hiz     = in_reset(s.state);
  assign init_image             = s.image;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Checks below sample the state record directly, so they follow the
  // sequencer even where the outputs are only levels.
  // A release seen in pause with fast CPU clock and no reset pending.
  sequence fast_pause_s;
    s.state == ST_PAUSE && !s.slow_lat && pin_high && !wdt_overflow;
  endsequence

  // The same release seen at the slow CPU clock; the window then scales
  // with the divider, so it is written in pclk cycles below.
  sequence slow_pause_s;
    s.state == ST_PAUSE && s.slow_lat && pin_high && !wdt_overflow;
  endsequence

  // Slow vectored window in pclk cycles: nine to ten CPU clocks.
  localparam int SLOW_VEC_LO = WAKE_VEC_CLKS * DIV_SLOW;
  localparam int SLOW_VEC_HI = (WAKE_VEC_CLKS + 1) * DIV_SLOW;

  AST_MASKED_STAYS: assert property (
    fast_pause_s and (!unmasked && !nmi_req) |=> s.state == ST_PAUSE)
    else $error("Pause left without an unmasked request.");
  AST_VEC_WAKE: assert property (
    fast_pause_s and (unmasked && s.program_status_word[PSW_IE_BIT] && !nmi_req)
      |-> ##[9:10] cpu_ctrl.service_start)
    else $error("Vectored service not started 9-10 clocks after release.");
  AST_RESUME_WAKE: assert property (
    fast_pause_s and (unmasked && !s.program_status_word[PSW_IE_BIT] && !nmi_req)
      |-> ##[1:2] cpu_ctrl.resume_start)
    else $error("Resume not started 1-2 clocks after release.");
  AST_NMI_WAKE: assert property (
    fast_pause_s and (nmi_req && !s.program_status_word[PSW_IE_BIT])
      |-> ##[9:10] (cpu_ctrl.service_start && cpu_ctrl.service_nmi))
    else $error("Non-maskable release did not give vectored service.");
  AST_PIN_HOLDS: assert property (
    !pin_high |=> cpu_ctrl.core_reset && !cpu_ctrl.cpu_clk_en)
    else $error("Core not held while reset pin low.");
  AST_HIZ_SUBOSC: assert property (
    cpu_ctrl.core_reset |-> osc_ctrl.ports_hiz && osc_ctrl.sub_osc_run)
    else $error("Pins not hi-Z or subclock off in reset.");
  AST_EXT_OSC_STOP: assert property (
    s.state == ST_EXT_RESET |-> !osc_ctrl.main_osc_run)
    else $error("Main oscillator runs under pin reset.");
  AST_WDT_OSC: assert property (
    (pin_high && wdt_overflow && !in_reset(s.state))
      |=> s.state == ST_WDT_RESET && osc_ctrl.main_osc_run == !$past(s.main_clock_stop_control))
    else $error("Watchdog reset changed main oscillator state.");
  AST_RESET_VALUES: assert property (
    cpu_ctrl.core_reset |-> s.program_status_word == PSW_RST && s.processor_clock_control == PCC_RST &&
      s.req == REQ_RST && s.mask == MASK_RST && !cpu_ctrl.pc_valid)
    else $error("Register reset values wrong during reset.");
  AST_FETCH: assert property (
    $fell(cpu_ctrl.core_reset) |-> cpu_ctrl.vector_fetch &&
      cpu_ctrl.vector_addr == VEC_ADDR_LO && $past(s.state) == ST_REG_WAIT)
    else $error("Reset exit without vector fetch.");
  AST_PAUSE_CLK: assert property (
    s.state == ST_PAUSE |-> !cpu_ctrl.cpu_clk_en && s.main_osc == !s.main_clock_stop_control)
    else $error("Pause did not stop only the CPU clock.");
  AST_SLOW_VEC_WAKE: assert property (
    slow_pause_s and (nmi_req || (unmasked && s.program_status_word[PSW_IE_BIT]))
      |-> ##[SLOW_VEC_LO:SLOW_VEC_HI] cpu_ctrl.service_start)
    else $error("Slow vectored service not started 9-10 CPU clocks after release.");
  // Both waits after a pin reset run the main oscillator; after a watchdog reset only the regulator wait does.
  AST_WAIT_OSC_RUN: assert property (
    (s.state == ST_INT_WAIT || s.state == ST_REG_WAIT) |-> osc_ctrl.main_osc_run)
    else $error("Main oscillator stopped during a reset wait.");
  // The wake count must use the speed in force when the pause began.
  AST_SPEED_LATCH: assert property (
    (s.state == ST_RUN && halt_req) |=> s.slow_lat == $past(s.processor_clock_control[PCC_SPEED_BIT]))
    else $error("Pause entry did not latch the CPU speed.");

endmodule : pause_release_and_reset_ctrl

// ### hw/pause_reset_pkg.sv
// Constants and types for the pause-release and reset sequencer.
// Assumes a 125 MHz pclk and an APB register bus with 8-bit addresses.
package pause_reset_pkg;
  // Timing: regulator wait 0.5 s, counted in pclk cycles.
  localparam int CLK_MHZ         = 125;
  localparam int REG_STAB_US     = 500000;
  localparam int REG_STAB_CYC    = REG_STAB_US * CLK_MHZ;
  localparam int INT_RST_CYC     = 1024;  // Internal reset wait, plain default.
  localparam int CNT_W           = 26;
  localparam int WAKE_VEC_CLKS   = 9;     // CPU clocks before vectored service.
  localparam int WAKE_RES_CLKS   = 1;     // CPU clocks before plain resume.
  localparam int DIV_SLOW        = 4;     // pclk per CPU clock, low speed.
  localparam int DIV_FAST        = 1;     // pclk per CPU clock, high speed.
  localparam int IRQ_NUM         = 8;
  // Register byte offsets.
  localparam logic [7:0] ADDR_PSW  = 8'h00;
  localparam logic [7:0] ADDR_PCC  = 8'h04;
  localparam logic [7:0] ADDR_MCC  = 8'h08;
  localparam logic [7:0] ADDR_REQ  = 8'h0C;
  localparam logic [7:0] ADDR_MASK = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;
  // Field positions and reset values.
  localparam int PSW_IE_BIT    = 7;
  localparam int PCC_SPEED_BIT = 1;
  localparam logic [7:0] PSW_RST  = 8'h02;
  localparam logic [7:0] PCC_RST  = 8'h02;
  localparam logic [7:0] REQ_RST  = 8'h00;
  localparam logic [7:0] MASK_RST = 8'hFF;
  localparam logic [15:0] VEC_ADDR_LO = 16'h0000;
  // Control states of the sequencer.
  typedef enum logic [2:0] {
    ST_EXT_RESET, ST_WDT_RESET, ST_INT_WAIT, ST_REG_WAIT, ST_RUN, ST_PAUSE, ST_WAKE
  } state_type;
  // Strobes and levels toward the CPU core.
  typedef struct packed {
    logic        core_reset;    // Core held in reset.
    logic        cpu_clk_en;    // CPU clock gated on.
    logic        pc_valid;      // Program counter defined.
    logic        vector_fetch;  // Pulse: fetch start address.
    logic [15:0] vector_addr;   // Low byte address of reset vector.
    logic        service_start; // Pulse: begin vectored service.
    logic        service_nmi;   // Service is non-maskable.
    logic        resume_start;  // Pulse: resume at next address.
  } cpu_ctrl_type;
  // Oscillator and pad control.
  typedef struct packed {
    logic main_osc_run;
    logic sub_osc_run;
    logic ports_hiz;
  } osc_ctrl_type;
  // Values that peripherals load while the core reset stands.
  typedef struct packed {
    logic [7:0]  port_latch;
    logic [7:0]  port_direction_reg;
    logic [7:0]  serial_tx_shift_reg;
    logic [7:0]  serial_rx_buffer_reg;
    logic [7:0]  serial_mode_reg;
    logic [7:0]  serial_status_reg;
    logic [7:0]  baud_generator_control;
    logic [15:0] wide_timer_counter;
    logic [15:0] wide_capture_compare_a;
    logic [15:0] wide_capture_compare_b;
    logic [7:0]  narrow_timer_counter;
  } init_image_type;
  localparam init_image_type INIT_IMAGE = '{
    port_latch: 8'h00, port_direction_reg: 8'hFF,
    serial_tx_shift_reg: 8'hFF, serial_rx_buffer_reg: 8'hFF,
    serial_mode_reg: 8'h01, serial_status_reg: 8'h00,
    baud_generator_control: 8'h1F, wide_timer_counter: 16'h0000,
    wide_capture_compare_a: 16'h0000, wide_capture_compare_b: 16'h0000,
    narrow_timer_counter: 8'h00};
endpackage : pause_reset_pkg

// ### verification/irq_reset_source_model.sv
// Model of the interrupt sources, the watchdog and the board reset circuit.
// Assumes one pclk; every output changes by NBA just after a rising edge.
`timescale 1ns/1ns
module irq_reset_source_model
  import pause_reset_pkg::*;
#(
  parameter int MIN_LOW = 1250  // Shortest reset pin low time, 10 us of pclk.
) (
  // Clock.
  input  wire logic               pclk,
  // Request and reset lines toward the sequencer.
  output      logic [IRQ_NUM-1:0] irq_req,
  output      logic               nmi_req,
  output      logic               wdt_overflow,
  output      logic               reset_pin_n
);
  // All lines idle at time zero; the pin rests high as with its pull-up.
  initial begin
    irq_req      = '0;
    nmi_req      = 1'b0;
    wdt_overflow = 1'b0;
    reset_pin_n  = 1'b1;
  end
  // One-cycle pulse: indexes below IRQ_NUM are maskable, then the
  // non-maskable line, then the watchdog overflow.
  task pulse(input int which);
    @(posedge pclk);
    if (which < IRQ_NUM) begin
      irq_req[which] <= 1'b1;
    end else if (which == IRQ_NUM) begin
      nmi_req <= 1'b1;
    end else begin
      wdt_overflow <= 1'b1;
    end
    @(posedge pclk);
    irq_req      <= '0;
    nmi_req      <= 1'b0;
    wdt_overflow <= 1'b0;
  endtask : pulse
  // A short request is stretched, since a shorter pulse is not a valid reset.
  task pin_reset(input int cycles);
    int n;
    n = (cycles < MIN_LOW) ? MIN_LOW : cycles;
    @(posedge pclk);
    reset_pin_n <= 1'b0;
    repeat (n) @(posedge pclk);
    reset_pin_n <= 1'b1;
  endtask : pin_reset
endmodule : irq_reset_source_model

// ### verification/tb.sv
// Self-checking bench for the pause-release and reset sequencer.
// Assumes the package constants and short waits of 8 and 20 cycles.
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin errors++; \
  $display("MISMATCH %s exp=%0h got=%0h", nm, exp, got); end end
module tb;
  import pause_reset_pkg::*;
  localparam int INT_W  = 8;   // Shortened internal reset wait.
  localparam int STAB_W = 20;  // Shortened regulator wait.
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic               reset_pin_n, wdt_overflow, nmi_req, halt_req;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata;
  logic [IRQ_NUM-1:0] irq_req;
  cpu_ctrl_type       cpu_ctrl;
  osc_ctrl_type       osc_ctrl;
  init_image_type     init_image;
  int                 errors, check_count, cyc;
  pause_release_and_reset_ctrl #(.INT_RST_WAIT(INT_W), .REG_STAB(STAB_W)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_pin_n(reset_pin_n), .wdt_overflow(wdt_overflow), .irq_req(irq_req),
    .nmi_req(nmi_req), .halt_req(halt_req), .cpu_ctrl(cpu_ctrl), .osc_ctrl(osc_ctrl),
    .init_image(init_image));
  irq_reset_source_model src (.pclk(pclk), .irq_req(irq_req), .nmi_req(nmi_req),
    .wdt_overflow(wdt_overflow), .reset_pin_n(reset_pin_n));
  // Prints the counts and the verdict, then ends the run.
  task stop_test();
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  // One APB transfer; the request stands until pready is seen high.
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  // Reads a register and compares the bits under the mask.
  task reg_chk(input string nm, input logic [7:0] a, input logic [31:0] m,
               input logic [31:0] exp);
    logic [31:0] d;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, d, e);
    `CHK(nm, exp, d & m)
  endtask : reg_chk
  // Counts edges until a core strobe shows: 0 fetch, 1 service, 2 resume.
  task wait_for(input int which, output int n);
    logic s;
    for (n = 1; n < 400; n++) begin
      @(posedge pclk);
      #1;
      s = (which == 0) ? cpu_ctrl.vector_fetch :
          (which == 1) ? cpu_ctrl.service_start : cpu_ctrl.resume_start;
      if (s === 1'b1) break;
    end
  endtask : wait_for
  task halt_pulse();
    @(posedge pclk);
    halt_req <= 1'b1;
    @(posedge pclk);
    halt_req <= 1'b0;
  endtask : halt_pulse
  // Power-on reset: held values, the two waits, then the register image.
  task t_reset();
    logic [31:0] d;
    logic        e;
    int          n;
    #1;
    `CHK("core_reset", 1'b1, cpu_ctrl.core_reset)
    `CHK("ports_hiz", 1'b1, osc_ctrl.ports_hiz)
    `CHK("sub_osc", 1'b1, osc_ctrl.sub_osc_run)
    `CHK("pc_valid", 1'b0, cpu_ctrl.pc_valid)
    `CHK("init_image", INIT_IMAGE, init_image)
    @(posedge pclk);
    presetn <= 1'b1;
    wait_for(0, n);
    `CHK("reset_wait", 1'b1, n >= INT_W + STAB_W && n <= INT_W + STAB_W + 3)
    `CHK("pc_valid_run", 1'b1, cpu_ctrl.pc_valid)
    `CHK("vector", VEC_ADDR_LO, cpu_ctrl.vector_addr)
    `CHK("ports_driven", 1'b0, osc_ctrl.ports_hiz)
    reg_chk("psw", ADDR_PSW, 32'hFFFF_FFFF, {24'h00_0000, PSW_RST});
    reg_chk("pcc", ADDR_PCC, 32'hFFFF_FFFF, {24'h00_0000, PCC_RST});
    reg_chk("req", ADDR_REQ, 32'hFFFF_FFFF, {24'h00_0000, REQ_RST});
    reg_chk("mask", ADDR_MASK, 32'hFFFF_FFFF, {24'h00_0000, MASK_RST});
    reg_chk("mcc", ADDR_MCC, 32'hFFFF_FFFF, 32'h0000_0000);
    apb(1'b0, 8'h18, 32'h0000_0000, d, e);
    `CHK("unmapped_err", 1'b1, e)
  endtask : t_reset
  // Pause, then release by a maskable or non-maskable request.
  task t_wake(input logic ie, input logic nmi, input logic fast, input int lo,
              input int hi);
    int n;
    wr(ADDR_PCC, fast ? 32'h0000_0000 : 32'h0000_0002);
    wr(ADDR_PSW, {24'h00_0000, ie, 7'h02});
    wr(ADDR_MASK, 32'h0000_00FF);
    halt_pulse();
    src.pulse(nmi ? IRQ_NUM : 0);
    if (!nmi) begin
      // The masked request must leave the core paused.
      reg_chk("paused", ADDR_STAT, 32'h0000_0007, 32'h0000_0005);
      `CHK("clk_stopped", 1'b0, cpu_ctrl.cpu_clk_en)
      wr(ADDR_MASK, 32'h0000_00FE);
    end
    wait_for((ie || nmi) ? 1 : 2, n);
    `CHK("wake_delay", 1'b1, n >= lo && n <= hi)
    `CHK("clk_running", 1'b1, cpu_ctrl.cpu_clk_en)
    `CHK("nmi_cause", nmi, cpu_ctrl.service_nmi & (ie | nmi))
    wr(ADDR_REQ, 32'h0000_0001);
    reg_chk("req_clear", ADDR_REQ, 32'hFFFF_FFFF, 32'h0000_0000);
  endtask : t_wake
  // Reset pin during pause; the main oscillator stops only while it is low.
  task t_pin();
    int n;
    halt_pulse();
    fork
      src.pin_reset(1250);
      begin
        repeat (600) @(posedge pclk);
        #1;
        `CHK("pin_core_reset", 1'b1, cpu_ctrl.core_reset)
        `CHK("pin_osc_stop", 1'b0, osc_ctrl.main_osc_run)
        `CHK("pin_sub_osc", 1'b1, osc_ctrl.sub_osc_run)
      end
    join
    repeat (5) @(posedge pclk);
    #1;
    `CHK("wait_osc_run", 1'b1, osc_ctrl.main_osc_run)
    `CHK("wait_hiz", 1'b1, osc_ctrl.ports_hiz)
    wait_for(0, n);
    `CHK("pin_refetch", 1'b1, n < 400)
    reg_chk("pin_pcc", ADDR_PCC, 32'hFFFF_FFFF, {24'h00_0000, PCC_RST});
  endtask : t_pin
  // Watchdog reset with the main oscillator stopped beforehand.
  task t_wdt();
    int n;
    wr(ADDR_MCC, 32'h0000_0001);
    src.pulse(IRQ_NUM + 1);
    repeat (2) @(posedge pclk);
    #1;
    `CHK("wdt_core_reset", 1'b1, cpu_ctrl.core_reset)
    `CHK("wdt_osc_kept", 1'b0, osc_ctrl.main_osc_run)
    repeat (INT_W) @(posedge pclk);
    `CHK("wdt_osc_run", 1'b1, osc_ctrl.main_osc_run)
    `CHK("wdt_stab_hold", 1'b1, cpu_ctrl.core_reset)
    wait_for(0, n);
    `CHK("wdt_fetch", 1'b1, n < 400)
    reg_chk("wdt_cause", ADDR_STAT, 32'h0000_0020, 32'h0000_0020);
    reg_chk("wdt_mcc", ADDR_MCC, 32'hFFFF_FFFF, 32'h0000_0000);
  endtask : t_wdt
  // Free-running 125 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // A hang is cut short well beyond the expected run length.
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      errors++;
      stop_test();
    end
  end
  // Main sequence; the pause scenarios run fast, slow, fast, fast so PROCESSOR_CLOCK_CONTROL ends fast.
  initial begin
    {presetn, psel, penable, pwrite, halt_req} = '0;
    paddr  = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (2) @(posedge pclk);
    t_reset();
    t_wake(1'b0, 1'b0, 1'b1, 2, 4);
    t_wake(1'b0, 1'b1, 1'b0, 36, 40);
    t_wake(1'b1, 1'b0, 1'b1, 9, 12);
    t_wake(1'b0, 1'b1, 1'b1, 9, 10);
    t_pin();
    t_wdt();
    stop_test();
  end
endmodule : tb
